// File: hcbi_host_model.sv
`timescale 1ns/1ps
module hcbi_host_model (
  // Clock
  input  wire logic             core_clk,
  // Host pins
  output hcbi_pkg::hcbi_host_type host
);
  import hcbi_pkg::*;
  initial host = '{cs_n: 1'h1, rw: 1'h1, oe_n: 1'h1, addr: 8'h00, din: 16'h0000};
  // Line style holds oe_n low; strobe style uses oe_n as read strobe
  task automatic xfer(input logic sty, input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    host <= '{cs_n: 1'h0, rw: ~wr, oe_n: sty & ~wr ? 1'h0 : sty, addr: a, din: d};
  endtask
  // Strobe style ends on its strobe first, select follows a cycle later
  task automatic done(input logic sty, input logic wr);
    @(negedge core_clk);
    if (sty) begin
      if (wr) host.rw <= 1'h1;
      else host.oe_n <= 1'h1;
      @(negedge core_clk);
    end
    host.cs_n <= 1'h1;
    host.din  <= ~host.din;
  endtask
endmodule

// File: hcbi_pkg.sv
// Overview of operation
// - The port accepts both the direction-line bus style and the separate-strobe bus style with no style-select pin.
// - A read drives register data when select is low with the strobe high and output enable low.
// - Write data is captured into a pre-load register on the first rising edge of the strobe or of select.
// - Pre-loaded data reaches the addressed internal register within 2 system clock cycles.
package hcbi_pkg;

  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;
  localparam int NUM_REGS      = 256;
  localparam int WR_LAT_CYCLES = 2;

  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;

  typedef struct packed {
    logic              cs_n;
    logic              rw;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
  } hcbi_host_type;

  typedef struct packed {
    logic              wr_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hcbi_wr_type;

endpackage

// File: hcbi_port.sv
`timescale 1ns/1ps
module hcbi_port (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // Host pins
  input  wire hcbi_pkg::hcbi_host_type       host,
  output logic [hcbi_pkg::DATA_W-1:0]        host_dout,
  output logic                               host_doe_n,
  // Register file write side and status
  output hcbi_pkg::hcbi_wr_type              reg_wr,
  output logic                               busy
);
  import hcbi_pkg::*;

  // Write capture state
  logic              wsel_q;
  logic              wsel_d;
  logic              wr_close;
  logic [DATA_W-1:0] pre_data_q;
  logic [DATA_W-1:0] pre_data_d;
  logic [ADDR_W-1:0] pre_addr_q;
  logic [ADDR_W-1:0] pre_addr_d;
  logic              pend_q;
  logic              pend_d;
  // Commit state
  hcbi_wr_type       wr_q;
  hcbi_wr_type       wr_d;
  // Register file
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic [DATA_W-1:0] regs_d [NUM_REGS];
  // Read path state
  logic              rd_act;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic              doe_n_q;
  logic              doe_n_d;
  // Close-to-commit monitor state
  logic [1:0]        since_close_q;
  logic [1:0]        since_close_d;

  // Read qualifier works for both styles: oe_n is tied low in line style
  assign rd_act = !host.cs_n && host.rw && !host.oe_n;

  // Strobe rising in strobe style and select rising in line style both end the write term,
  // so one detector serves either style and no style pin is needed
  always_comb begin
    wsel_d     = !host.cs_n && !host.rw;
    wr_close   = wsel_q && !wsel_d;
    pre_data_d = pre_data_q;
    pre_addr_d = pre_addr_q;
    pend_d     = wr_close;
    // Bus is tracked while the term holds, so the last sample before the close is kept
    if (wsel_d) begin
      pre_data_d = host.din;
      pre_addr_d = host.addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wsel_q     <= 1'h0;
      pre_data_q <= '0;
      pre_addr_q <= '0;
      pend_q     <= 1'h0;
    end else begin
      wsel_q     <= wsel_d;
      pre_data_q <= pre_data_d;
      pre_addr_q <= pre_addr_d;
      pend_q     <= pend_d;
    end
  end

  // Commit one cycle after the pre-load closes, inside the 2 cycle budget
  always_comb begin
    wr_d = '0;
    if (pend_q) begin
      wr_d.wr_stb = 1'h1;
      wr_d.addr   = pre_addr_q;
      wr_d.data   = pre_data_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

  // One word per address; only the committed address loads, in the same cycle as the strobe
  for (genvar g = 0; g < NUM_REGS; g++) begin : gen_reg
    always_comb begin
      regs_d[g] = regs_q[g];
      if (pend_q && (pre_addr_q == ADDR_W'(g))) begin
        regs_d[g] = pre_data_q;
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        regs_q[g] <= REG_RST;
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // Registered output costs one cycle; host access time far exceeds 5 ns
  always_comb begin
    doe_n_d = !rd_act;
    dout_d  = '0;
    if (rd_act) begin
      dout_d = regs_q[host.addr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dout_q  <= '0;
      doe_n_q <= 1'h1;
    end else begin
      dout_q  <= dout_d;
      doe_n_q <= doe_n_d;
    end
  end

  // Saturating edge count since the last write close; checks the commit budget as a number
  always_comb begin
    since_close_d = since_close_q;
    if (wr_close) begin
      since_close_d = 2'h0;
    end else if (since_close_q != 2'h3) begin
      since_close_d = since_close_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      since_close_q <= 2'h3;
    end else begin
      since_close_q <= since_close_d;
    end
  end

  assign host_dout  = dout_q;
  assign host_doe_n = doe_n_q;
  assign reg_wr     = wr_q;
  assign busy       = pend_q;

  chk_write_commit_time: assert property (@(posedge core_clk) disable iff (!rstn)
    (wsel_q && !wsel_d) |-> ##2 (reg_wr.wr_stb && reg_wr.addr == $past(pre_addr_q, 1)))
    else $error("write not committed within 2 cycles");
  chk_read_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_act |=> (!host_doe_n && host_dout == $past(regs_q[host.addr])))
    else $error("read data not driven");
  chk_bus_release: assert property (@(posedge core_clk) disable iff (!rstn)
    !rd_act |=> host_doe_n)
    else $error("bus driven outside read");
  chk_no_drive_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (!host.cs_n && !host.rw) |=> host_doe_n)
    else $error("bus driven during write");
  chk_line_style_read: assert property (@(posedge core_clk) disable iff (!rstn)
    (!host.cs_n && host.rw && !host.oe_n) |=> !host_doe_n)
    else $error("read with tied output enable ignored");
  chk_preload_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    (wsel_q && !wsel_d) |=> (pend_q && pre_data_q == $past(pre_data_q)))
    else $error("pre-load changed after close");
  chk_single_commit: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_wr.wr_stb |=> !reg_wr.wr_stb)
    else $error("duplicate commit");
  chk_reg_value: assert property (@(posedge core_clk) disable iff (!rstn)
    pend_q |=> regs_q[$past(pre_addr_q)] == $past(pre_data_q))
    else $error("register not updated");

  // Bus stays released outside a qualified read, and in reset
  chk_reset_quiet: assert property (@(posedge core_clk)
    !rstn |=> (host_doe_n && host_dout == '0 && !busy && !reg_wr.wr_stb))
    else $error("outputs not quiet after reset");
  chk_idle_dout_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    host_doe_n |-> (host_dout == '0))
    else $error("data shown while bus released");
  chk_oe_blocks_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    host.oe_n |=> host_doe_n)
    else $error("bus driven with read strobe high");
  chk_deselect_release: assert property (@(posedge core_clk) disable iff (!rstn)
    host.cs_n |=> host_doe_n)
    else $error("bus driven while deselected");
  chk_write_no_data: assert property (@(posedge core_clk) disable iff (!rstn)
    (!host.cs_n && !host.rw) |=> (host_dout == '0))
    else $error("read data shown during write");

  // Pre-load tracks the bus in either style and freezes once the term ends
  chk_preload_track: assert property (@(posedge core_clk) disable iff (!rstn)
    wsel_d |=> (pre_data_q == $past(host.din) && pre_addr_q == $past(host.addr)))
    else $error("pre-load missed bus sample");
  chk_preload_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !wsel_d |=> ($stable(pre_data_q) && $stable(pre_addr_q)))
    else $error("pre-load moved outside write");
  chk_strobe_style_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (!host.cs_n && !host.rw && host.oe_n) |=> (pre_data_q == $past(host.din)))
    else $error("strobe style write not captured");
  chk_line_style_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (!host.cs_n && !host.rw && !host.oe_n) |=> (pre_addr_q == $past(host.addr)))
    else $error("line style write not captured");

  // Commit is a single strobe that follows busy and lands in the register file
  chk_busy_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    busy |=> !busy)
    else $error("busy longer than one cycle");
  chk_busy_to_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
    busy |=> reg_wr.wr_stb)
    else $error("busy without commit strobe");
  chk_strobe_from_busy: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_wr.wr_stb |-> $past(busy))
    else $error("commit strobe without busy");
  chk_no_stray_commit: assert property (@(posedge core_clk) disable iff (!rstn)
    !busy |=> !reg_wr.wr_stb)
    else $error("commit strobe with no pending write");
  chk_commit_data: assert property (@(posedge core_clk) disable iff (!rstn)
    (wsel_q && !wsel_d) |-> ##2 (reg_wr.data == $past(pre_data_q, 1)))
    else $error("committed data differs from pre-load");
  chk_commit_stored: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_wr.wr_stb |-> (regs_q[reg_wr.addr] == reg_wr.data))
    else $error("register differs from committed data");
  chk_commit_budget: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_wr.wr_stb |-> (since_close_q < 2'(WR_LAT_CYCLES)))
    else $error("commit later than budget");

endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import hcbi_pkg::*;
  logic              core_clk = 1'h0;
  logic              rstn = 1'h0;
  hcbi_host_type     host;
  logic [DATA_W-1:0] host_dout;
  logic              host_doe_n;
  hcbi_wr_type       reg_wr;
  logic              busy;
  int                failures = 0;
  int                num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  hcbi_host_model hcbi_host_model_inst (.core_clk(core_clk), .host(host));
  hcbi_port hcbi_port_inst (.core_clk(core_clk), .rstn(rstn), .host(host), .host_dout(host_dout),
    .host_doe_n(host_doe_n), .reg_wr(reg_wr), .busy(busy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_write(input logic sty, input logic [7:0] a, input logic [15:0] d);
    hcbi_host_model_inst.xfer(sty, 1'h1, a, d);
    hcbi_host_model_inst.done(sty, 1'h1);
    // Strobe style closed on its strobe an edge before select rose, so busy already stands
    if (!sty) @(negedge core_clk);
    chk(busy, 1'h1);
    @(negedge core_clk); // Select stays high past here
    chk({reg_wr.wr_stb, reg_wr.addr, reg_wr.data}, {1'h1, a, d});
  endtask
  task automatic do_read(input logic sty, input logic [7:0] a, input logic [15:0] exp);
    hcbi_host_model_inst.xfer(sty, 1'h0, a, 16'h0000);
    @(negedge core_clk);
    chk({host_doe_n, host_dout}, {1'h0, exp});
    hcbi_host_model_inst.done(sty, 1'h0);
    repeat (2) @(negedge core_clk);
    chk({host_doe_n, host_dout}, {1'h1, 16'h0000});
  endtask
  task automatic scen_line();
    do_read(1'h0, 8'h5A, 16'h0000);
    do_write(1'h0, 8'h5A, 16'hA5C3);
    do_read(1'h0, 8'h5A, 16'hA5C3);
  endtask
  // Mixed styles on one port prove no style pin is needed
  task automatic scen_strobe();
    do_write(1'h1, 8'hFF, 16'hFFFF);
    do_write(1'h1, 8'h00, 16'h1234);
    do_read(1'h1, 8'hFF, 16'hFFFF);
    do_read(1'h0, 8'h00, 16'h1234);
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1'h1;
    scen_line();
    scen_strobe();
    complete_run();
  end
  // Traffic needs about 53 cycles, so 400 leaves ample margin
  initial begin
    #2000;
    failures++;
    complete_run();
  end
endmodule
